// >>> common/bsp_consts.svh
// constants of the clock-stop serial port block
// assumes inclusion by bare name from common/
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH
`define BSP_STOP_NO_DELAY 2'b10
`define BSP_STOP_HALF_DELAY 2'b11
`define BSP_SLAVE_DIV 8'h01
`define BSP_DIV_W 8
`define BSP_WORD_W 8
`define BSP_FIFO_DEPTH 8
`endif

// >>> common/bsp_pkg.sv
// types of the clock-stop serial port block
// assumes nothing beyond a SystemVerilog compiler
package bsp_pkg;
  typedef enum logic [2:0] {st_idle, st_lead, st_high, st_low, st_trail} bsp_state_t;
endpackage

// >>> verilog/bsp_top.sv
// clock-stop serial port with polarity 0, master or slave, and its tx FIFO
// assumes config ports stable while a word is in flight; pins synchronous to clk_sys
`timescale 1ns/10ps
`include "bsp_consts.svh"

// ----------------------------------------
// word FIFO with registered flags
// ----------------------------------------
module bsp_fifo #(
  parameter int W = `BSP_WORD_W,
  parameter int D = `BSP_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      // pointers wrap only for power-of-two depth
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != D[AW:0]);
      out_valid <= (next_count != '0);
    end
  end
endmodule

// ----------------------------------------
// serial port core
// ----------------------------------------
module bsp_top import bsp_pkg::*; #(
  parameter int W = `BSP_WORD_W,
  parameter int DEPTH = `BSP_FIFO_DEPTH,
  parameter int DW = `BSP_DIV_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] clock_stop_mode_field,
  input wire logic tx_clock_polarity,
  input wire logic gen_input_select,
  input wire logic [DW-1:0] gen_clock_divider,
  input wire logic gen_ext_clock_pin,
  input wire logic tx_sync_polarity,
  input wire logic rx_sync_polarity,
  input wire logic tx_clock_direction,
  input wire logic tx_sync_direction,
  input wire logic rx_clock_direction,
  input wire logic rx_sync_direction,
  input wire logic tx_shift_clock_pin_in,
  output logic tx_shift_clock_pin_out,
  output logic tx_shift_clock_pin_oe_n,
  input wire logic tx_frame_sync_pin_in,
  output logic tx_frame_sync_pin_out,
  output logic tx_frame_sync_pin_oe_n,
  input wire logic rx_frame_sync_pin_in,
  output logic tx_data_pin_out,
  output logic tx_data_pin_oe_n,
  input wire logic rx_data_pin,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [W-1:0] tx_data,
  output logic [W-1:0] rx_word,
  output logic rx_valid,
  output logic cfg_error,
  output logic busy
);
  localparam int BW = $clog2(W + 1);

  bsp_state_t state;
  logic [DW:0] cnt;
  logic [DW:0] high_len;
  logic [DW:0] low_len;
  logic [DW:0] half_up;
  logic [DW:0] len;
  logic int_tog;
  logic ext_prev;
  logic gen_tick;
  logic phase_done;
  logic mst;
  logic slv;
  logic half;
  logic stop_ok;
  logic sel;
  logic sel_prev;
  logic sclk_prev;
  logic frame_act;
  logic m_rise;
  logic m_fall;
  logic rise;
  logic fall;
  logic sample;
  logic advance;
  logic start;
  logic last_fall;
  logic [W-1:0] tx_shift;
  logic [W-1:0] rx_shift;
  logic [BW-1:0] bits;
  logic f_valid;
  logic f_ready;
  logic [W-1:0] f_data;

  bsp_fifo #(.W(W), .D(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign stop_ok = (clock_stop_mode_field == `BSP_STOP_NO_DELAY) ||
                   (clock_stop_mode_field == `BSP_STOP_HALF_DELAY);
  assign half = (clock_stop_mode_field == `BSP_STOP_HALF_DELAY);
  // only polarity 0 is supported; polarity 1 parks the port
  assign mst = tx_clock_direction && tx_sync_direction && !rx_clock_direction &&
               !rx_sync_direction && stop_ok && !tx_clock_polarity;
  assign slv = !tx_clock_direction && !tx_sync_direction && !rx_clock_direction &&
               !rx_sync_direction && stop_ok && !tx_clock_polarity &&
               gen_input_select && (gen_clock_divider == `BSP_SLAVE_DIV);
  // active-low select inputs turned active high before use
  assign sel = slv && ((tx_sync_polarity ? !tx_frame_sync_pin_in : tx_frame_sync_pin_in) ||
               (rx_sync_polarity ? !rx_frame_sync_pin_in : rx_frame_sync_pin_in));

  // ----------------------------------------
  // sample-rate generator
  // ----------------------------------------
  assign gen_tick = gen_input_select ? int_tog : (gen_ext_clock_pin && !ext_prev);
  assign half_up = ({1'b0, gen_clock_divider} + 1'b1) >> 1;

  always_comb begin
    // zero divider cannot split one input period, so each phase takes one
    if (!gen_clock_divider[0] && gen_clock_divider != '0) begin
      high_len = {1'b0, gen_clock_divider >> 1} + 1'b1;
      low_len = {1'b0, gen_clock_divider >> 1};
    end else begin
      high_len = (half_up == '0) ? (DW+1)'(1) : half_up;
      low_len = (half_up == '0) ? (DW+1)'(1) : half_up;
    end
  end

  always_comb begin
    len = low_len;
    unique case (state)
      st_idle: len = low_len;
      st_lead: len = half ? (DW+1)'(high_len + low_len) : low_len;
      st_high: len = high_len;
      st_low: len = low_len;
      st_trail: len = half ? low_len : (DW+1)'(high_len + low_len);
    endcase
  end

  assign phase_done = gen_tick && ((cnt + 1'b1) >= len);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_tog <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      int_tog <= !int_tog;
      ext_prev <= gen_ext_clock_pin;
    end
  end

  // ----------------------------------------
  // edge events shared by master and slave
  // ----------------------------------------
  assign m_rise = mst && phase_done && (state == st_lead || state == st_low);
  assign m_fall = mst && phase_done && (state == st_high);
  assign rise = m_rise || (slv && sel && tx_shift_clock_pin_in && !sclk_prev);
  assign fall = m_fall || (slv && sel && !tx_shift_clock_pin_in && sclk_prev);
  assign sample = half ? rise : fall;
  assign advance = half ? fall : (rise && bits != '0);
  // master words start on a generator tick so the select lead is exact
  assign start = (mst && state == st_idle && f_valid && gen_tick) || (sel && !sel_prev);
  assign f_ready = start;
  assign last_fall = m_fall && (half ? (bits == BW'(W)) : (bits == BW'(W - 1)));

  // ----------------------------------------
  // master sequencer, shift clock and select
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= st_idle;
      cnt <= '0;
      frame_act <= 1'b0;
      tx_shift_clock_pin_out <= 1'b0;
      tx_frame_sync_pin_out <= 1'b0;
    end else begin
      if (phase_done || state == st_idle) begin
        cnt <= '0;
      end else if (gen_tick) begin
        cnt <= cnt + 1'b1;
      end
      unique case (state)
        st_idle: begin
          tx_shift_clock_pin_out <= 1'b0;
          if (mst && f_valid && gen_tick) begin
            state <= st_lead;
            frame_act <= 1'b1;
          end
        end
        st_lead, st_low: begin
          if (phase_done) begin
            state <= st_high;
            tx_shift_clock_pin_out <= 1'b1;
          end
        end
        st_high: begin
          if (phase_done) begin
            state <= last_fall ? st_trail : st_low;
            tx_shift_clock_pin_out <= 1'b0;
          end
        end
        st_trail: begin
          if (phase_done) begin
            state <= st_idle;
            frame_act <= 1'b0;
          end
        end
      endcase
      if (!mst) begin
        state <= st_idle;
        frame_act <= 1'b0;
      end
      // select leaves the pin inverted when its polarity bit is set
      tx_frame_sync_pin_out <= tx_sync_polarity ? !next_frame() : next_frame();
    end
  end

  function automatic logic next_frame();
    logic f;
    f = frame_act;
    if (state == st_idle && mst && f_valid && gen_tick) begin
      f = 1'b1;
    end
    if (state == st_trail && phase_done) begin
      f = 1'b0;
    end
    if (!mst) begin
      f = 1'b0;
    end
    return f;
  endfunction

  // ----------------------------------------
  // pin directions and data drive
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_shift_clock_pin_oe_n <= 1'b1;
      tx_frame_sync_pin_oe_n <= 1'b1;
      tx_data_pin_oe_n <= 1'b1;
      cfg_error <= 1'b0;
      busy <= 1'b0;
      sel_prev <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      tx_shift_clock_pin_oe_n <= !mst;
      tx_frame_sync_pin_oe_n <= !mst;
      cfg_error <= !mst && !slv;
      busy <= (state != st_idle) || sel;
      sel_prev <= sel;
      sclk_prev <= tx_shift_clock_pin_in;
      if (slv) begin
        tx_data_pin_oe_n <= !sel;
      end else if (start) begin
        tx_data_pin_oe_n <= 1'b0;
      end else if (state == st_trail && (half ? phase_done : (gen_tick && cnt + 1'b1 >= low_len))) begin
        tx_data_pin_oe_n <= 1'b1;
      end else if (!mst) begin
        tx_data_pin_oe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // shifters and received word
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_shift <= '0;
      rx_shift <= '0;
      bits <= '0;
      rx_word <= '0;
      rx_valid <= 1'b0;
      tx_data_pin_out <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (start) begin
        // an empty FIFO at slave select sends zeros
        tx_shift <= f_valid ? f_data : '0;
        tx_data_pin_out <= f_valid ? f_data[W-1] : 1'b0;
        bits <= '0;
      end else begin
        if (sample && bits < BW'(W)) begin
          rx_shift <= {rx_shift[W-2:0], rx_data_pin};
          bits <= bits + 1'b1;
          if (bits == BW'(W - 1)) begin
            rx_word <= {rx_shift[W-2:0], rx_data_pin};
            rx_valid <= 1'b1;
          end
        end
        if (advance && bits < BW'(W)) begin
          tx_shift <= {tx_shift[W-2:0], 1'b0};
          tx_data_pin_out <= tx_shift[W-2];
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_lead_done;
    state == st_lead && phase_done;
  endsequence

  sequence s_idle2;
    state == st_idle ##1 state == st_idle;
  endsequence

  property p_slave_gen;
    @(posedge clk_sys) disable iff (rst)
      (slv && sel) |-> gen_input_select && gen_clock_divider == `BSP_SLAVE_DIV;
  endproperty
  a_slave_gen: assert property (p_slave_gen) else $error("slave without half-rate generator");

  property p_int_tick;
    @(posedge clk_sys) disable iff (rst)
      (gen_input_select && gen_tick) ##1 gen_input_select |-> !gen_tick;
  endproperty
  a_int_tick: assert property (p_int_tick) else $error("internal tick faster than two cycles");

  property p_period;
    @(posedge clk_sys) disable iff (rst)
      gen_clock_divider != '0 |-> high_len + low_len == gen_clock_divider + 1'b1;
  endproperty
  a_period: assert property (p_period) else $error("bit period not divider plus one");

  property p_phase_even;
    @(posedge clk_sys) disable iff (rst)
      (!gen_clock_divider[0] && gen_clock_divider != '0) |-> high_len == low_len + 1'b1;
  endproperty
  a_phase_even: assert property (p_phase_even) else $error("even divider phase split wrong");

  property p_phase_odd;
    @(posedge clk_sys) disable iff (rst)
      gen_clock_divider[0] |-> high_len == low_len;
  endproperty
  a_phase_odd: assert property (p_phase_odd) else $error("odd divider phases unequal");

  property p_sel_inv;
    @(posedge clk_sys) disable iff (rst)
      mst |=> tx_frame_sync_pin_out == ($past(tx_sync_polarity) ? !frame_act : frame_act);
  endproperty
  a_sel_inv: assert property (p_sel_inv) else $error("select pin polarity wrong");

  property p_mst_dir;
    @(posedge clk_sys) disable iff (rst)
      mst |=> !tx_shift_clock_pin_oe_n && !tx_frame_sync_pin_oe_n;
  endproperty
  a_mst_dir: assert property (p_mst_dir) else $error("master not driving clock and select");

  property p_slv_dir;
    @(posedge clk_sys) disable iff (rst)
      slv |=> tx_shift_clock_pin_oe_n && tx_frame_sync_pin_oe_n;
  endproperty
  a_slv_dir: assert property (p_slv_dir) else $error("slave driving clock or select");

  property p_lead;
    @(posedge clk_sys) disable iff (rst)
      s_lead_done |=> tx_shift_clock_pin_out && frame_act;
  endproperty
  a_lead: assert property (p_lead) else $error("no rising edge after select lead");

  property p_release;
    @(posedge clk_sys) disable iff (rst)
      (slv && !sel) |=> tx_data_pin_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("slave data pin not released");

  property p_idle_low;
    @(posedge clk_sys) disable iff (rst)
      (mst and s_idle2) |-> !tx_shift_clock_pin_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("shift clock not idle low");
endmodule

// >>> verif/bsp_spi_partner.sv
// far-side spi device, polarity 0, seen from the port in master mode
// assumes pins sampled on clk_sys and an active-low select
`timescale 1ns/10ps

// ----------------------------------------
// slave model
// ----------------------------------------
module bsp_spi_partner (
  input wire logic clk_sys,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic half,
  input wire logic [7:0] resp,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh;
  logic pc;
  logic ps;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    sh = 8'h00;
    pc = 1'b0;
    ps = 1'b1;
  end
  always @(posedge clk_sys) begin
    pc <= sclk;
    ps <= ss_n;
    if (ss_n) begin
      // released line: toggle so no stale bit can pass
      miso <= ~miso;
    end else if (ps) begin
      miso <= resp[7];
      sh <= half ? {resp[6:0], 1'b0} : resp;
    end else if (sclk != pc && sclk == half) begin
      got <= {got[6:0], mosi};
    end else if (sclk != pc) begin
      miso <= sh[7];
      sh <= {sh[6:0], 1'b0};
    end
  end
endmodule

// >>> verif/bsp_top_tb.sv
// testbench of the clock-stop serial port, master and slave roles
// assumes the partner model on the pins; inputs change at falling edges
`timescale 1ns/10ps

// ----------------------------------------
// bench
// ----------------------------------------
module bsp_top_tb;
  logic clk_sys, rst, gsel, ext, cxd, fxd, crd, tb_sck, tb_ss, tb_mosi, tv, m;
  logic [1:0] mode;
  logic [7:0] div, td, resp, rx_last;
  logic sck_o, sck_oe_n, fs_o, fs_oe_n, dx, dx_oe_n, trdy, rxv, cerr, bsy, miso;
  logic [7:0] rxw, got;
  logic sck, fs, rxd;
  int n_mismatch = 0;
  int tests_run = 0;
  int rxc = 0;
  int ecnt = 0;
  logic hv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0] dv [4] = '{8'h02, 8'h03, 8'h00, 8'h01};
  logic sv [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  int j;
  // pin levels resolved from the port's enables; rxd picked by the role flag m
  assign sck = sck_oe_n ? tb_sck : sck_o;
  assign fs = fs_oe_n ? tb_ss : fs_o;
  assign rxd = m ? miso : tb_mosi;

  bsp_top dut (.clk_sys(clk_sys), .rst(rst), .clock_stop_mode_field(mode), .tx_clock_polarity(1'b0),
    .gen_input_select(gsel), .gen_clock_divider(div), .gen_ext_clock_pin(ext), .tx_sync_polarity(1'b1),
    .rx_sync_polarity(1'b1), .tx_clock_direction(cxd), .tx_sync_direction(fxd),
    .rx_clock_direction(crd), .rx_sync_direction(1'b0), .tx_shift_clock_pin_in(sck),
    .tx_shift_clock_pin_out(sck_o), .tx_shift_clock_pin_oe_n(sck_oe_n), .tx_frame_sync_pin_in(fs),
    .tx_frame_sync_pin_out(fs_o), .tx_frame_sync_pin_oe_n(fs_oe_n), .rx_frame_sync_pin_in(1'b1),
    .tx_data_pin_out(dx), .tx_data_pin_oe_n(dx_oe_n), .rx_data_pin(rxd), .tx_valid(tv),
    .tx_ready(trdy), .tx_data(td), .rx_word(rxw), .rx_valid(rxv), .cfg_error(cerr), .busy(bsy));

  bsp_spi_partner sp (.clk_sys(clk_sys), .sclk(sck), .ss_n(fs), .mosi(dx), .half(mode[0]),
    .resp(resp), .miso(miso), .got(got));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // external generator clock, period 6 cycles
  always @(negedge clk_sys) begin
    ecnt <= (ecnt == 2) ? 0 : ecnt + 1;
    if (ecnt == 2) ext <= ~ext;
  end
  // rx_valid is a one-cycle pulse, so latch it here
  always @(posedge clk_sys) begin
    if (rxv === 1'b1) begin
      rxc <= rxc + 1;
      rx_last <= rxw;
    end
  end

  function automatic logic [7:0] wd(input int i);
    return 8'(i * 29 + 129);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic c, input string s);
    tests_run++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("mismatch t=%0t %s", $time, s);
    end
  endtask
  task automatic final_report();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic push(input logic [7:0] b);
    int c;
    tv = 1'b1;
    td = b;
    c = 0;
    while (trdy !== 1'b1 && c < 900) begin
      c++;
      tick(1);
    end
    tick(1);
    tv = 1'b0;
    tick(1);
  endtask
  task automatic run(input logic lv, output int c);
    c = 0;
    while (sck === lv && c < 900) begin
      c++;
      tick(1);
    end
  endtask
  task automatic cfg(input logic ms, input logic h, input logic [7:0] d, input logic s);
    m = ms;
    mode = {1'b1, h};
    div = d;
    gsel = s;
    cxd = ms;
    fxd = ms;
  endtask
  // one master word: phase widths counted in cycles against the divider
  task automatic mxfer(input logic h, input int d, input int s, input logic [7:0] w);
    int c, eh, el, x, i, k;
    eh = s * ((d == 0) ? 1 : (d % 2 == 0) ? d / 2 + 1 : (d + 1) / 2);
    el = s * ((d == 0) ? 1 : (d % 2 == 0) ? d / 2 : (d + 1) / 2);
    resp = ~w;
    k = rxc;
    c = 0;
    while (fs !== 1'b0 && c < 900) begin
      c++;
      tick(1);
    end
    run(1'b0, c);
    x = h ? eh + el : el;
    chk(c >= x - 1 && c <= x, "lead");
    for (i = 0; i < 8; i++) begin
      run(1'b1, c);
      chk(c == eh, "high phase");
      if (i < 7) begin
        run(1'b0, c);
        chk(c == el, "low phase");
      end
    end
    c = 0;
    while (fs !== 1'b1 && c < 900) begin
      c++;
      tick(1);
    end
    x = h ? el : eh + el;
    chk(c >= x - 1 && c <= x, "trail");
    chk(sck === 1'b0 && dx_oe_n === 1'b1, "idle pins");
    tick(2);
    chk(got === w && rxc == k + 1 && rx_last === ~w, "master data");
  endtask
  // one slave word with the bench as external master
  task automatic sxfer(input logic h, input logic [7:0] w, input logic [7:0] r);
    int i, k;
    k = rxc;
    tb_ss = 1'b0;
    tick(4);
    chk(dx_oe_n === 1'b0 && bsy === 1'b1, "slave select");
    for (i = 7; i >= 0; i--) begin
      if (h) tb_mosi = w[i];
      tick(4);
      if (h) chk(dx === r[i], "slave bit");
      tb_sck = 1'b1;
      if (!h) tb_mosi = w[i];
      tick(4);
      if (!h) chk(dx === r[i], "slave bit");
      tb_sck = 1'b0;
    end
    tick(4);
    chk(rxc == k + 1 && rx_last === w, "slave rx");
    tb_ss = 1'b1;
    tick(2);
    chk(dx_oe_n === 1'b1 && sck_oe_n === 1'b1 && fs_oe_n === 1'b1, "slave release");
  endtask

  initial begin
    rst = 1'b1;
    gsel = 1'b1;
    ext = 1'b0;
    cxd = 1'b0;
    fxd = 1'b0;
    crd = 1'b0;
    tb_sck = 1'b0;
    tb_ss = 1'b1;
    tb_mosi = 1'b0;
    tv = 1'b0;
    m = 1'b0;
    mode = 2'b00;
    div = 8'h02;
    td = 8'h00;
    resp = 8'h00;
    repeat (5) @(posedge clk_sys);
    tick(1);
    rst = 1'b0;
    tick(2);
    for (j = 0; j < 8; j++) push(wd(j));
    tick(2);
    chk(trdy === 1'b0, "fifo full");
    tv = 1'b1;
    td = 8'hee;
    tick(3);
    tv = 1'b0;
    cfg(1'b1, 1'b0, 8'h02, 1'b1);
    for (j = 0; j < 8; j++) mxfer(1'b0, 2, 2, wd(j));
    tick(40);
    chk(fs === 1'b1 && sck === 1'b0 && cerr === 1'b0, "drained");
    crd = 1'b1;
    tick(2);
    chk(cerr === 1'b1, "bad master dirs");
    crd = 1'b0;
    for (j = 0; j < 4; j++) begin
      cfg(1'b1, hv[j], dv[j], sv[j]);
      tick(2);
      push(wd(j + 8));
      mxfer(hv[j], int'(dv[j]), sv[j] ? 2 : 6, wd(j + 8));
    end
    cfg(1'b0, 1'b0, 8'h02, 1'b1);
    tick(2);
    chk(cerr === 1'b1, "slave div 2");
    div = 8'h01;
    tick(2);
    chk(cerr === 1'b0, "slave div 1");
    push(8'h5a);
    sxfer(1'b0, 8'hc3, 8'h5a);
    mode = 2'b11;
    push(8'h96);
    sxfer(1'b1, 8'h3c, 8'h96);
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule
